// *** common/dapw_pkg.sv ***
// constants and types for the display audio pin widget register bank
package dapw_pkg;

	// ***********************************************
	// register offsets in memory-mapped space
	// ***********************************************
	localparam int unsigned DAPW_ADDR_W = 20;
	localparam logic [19:0] DAPW_OFS_ENTRY_A = 20'h650a8;
	localparam logic [19:0] DAPW_OFS_ENTRY_B = 20'h651a8;
	localparam logic [19:0] DAPW_OFS_ENTRY_C = 20'h652a8;
	localparam logic [19:0] DAPW_OFS_SELECT = 20'h650ac;
	localparam logic [19:0] DAPW_OFS_STATUS = 20'h650c0;

	// ***********************************************
	// status register fields, transcoder a
	// ***********************************************
	localparam int unsigned DAPW_BIT_DESC_VALID_A = 0;
	localparam int unsigned DAPW_BIT_PROT_READY_A = 1;
	localparam int unsigned DAPW_BIT_ROUTE_ON_A = 2;
	localparam int unsigned DAPW_BIT_IDLE_A = 3;
	localparam logic DAPW_RST_DESC_VALID = 1'b0;
	localparam logic DAPW_RST_PROT_READY = 1'b0;
	localparam logic DAPW_RST_ROUTE_ON = 1'b0;
	localparam logic DAPW_RST_IDLE = 1'b0;

	// ***********************************************
	// connection list and select contents
	// ***********************************************
	localparam int unsigned DAPW_NUM_XCDR = 3;
	localparam logic [15:0] DAPW_ENTRY_RSVD = 16'h0000;
	localparam logic [7:0] DAPW_CONN_ENTRY_NODE = 8'h03;
	localparam logic DAPW_LONG_FORM = 1'b0;
	localparam logic [6:0] DAPW_LIST_LEN = 7'h01;
	localparam logic [7:0] DAPW_SEL_RSVD = 8'h00;
	localparam logic [7:0] DAPW_SEL_DEFAULT = 8'h0f;
	localparam logic [7:0] DAPW_WIDGET_PIPE_A = 8'h00;
	localparam logic [7:0] DAPW_WIDGET_PIPE_B = 8'h01;
	localparam logic [7:0] DAPW_WIDGET_PIPE_C = 8'h02;
	localparam logic [7:0] DAPW_CONN_INDEX_DEFAULT = 8'h00;

	// ***********************************************
	// widget query kinds
	// ***********************************************
	typedef enum logic {
		DAPW_Q_PIN,
		DAPW_Q_DEVICE
	} dapw_query_t;

endpackage

// *** common/dapw_conn_if.sv ***
// connection list and select words passed between the bank's modules
`timescale 1ns/1ps
interface dapw_conn_if;
	import dapw_pkg::*;
	logic [31:0] entry_len [DAPW_NUM_XCDR];
	logic [31:0] sel_word;
	modport prov(output entry_len, output sel_word);
	modport cons(input entry_len, input sel_word);
endinterface // dapw_conn_if

// *** core/dapw_conn_rom.sv ***
// fixed connection list entry, length and select words
`timescale 1ns/1ps
module dapw_conn_rom
	import dapw_pkg::*;
(
	dapw_conn_if.prov conn // fixed connection words
);

	// ***********************************************
	// one entry and length word per transcoder
	// ***********************************************
	genvar g;
	generate
		for (g = 0; g < DAPW_NUM_XCDR; g++) begin : g_entry
			assign conn.entry_len[g] = {DAPW_ENTRY_RSVD, DAPW_CONN_ENTRY_NODE,
				DAPW_LONG_FORM, DAPW_LIST_LEN}; // see [R5] see [R7] see [R8] see [R9] see [R12]
		end
	endgenerate

	// pipe c, b, a select fields over a zero top byte
	assign conn.sel_word = {DAPW_SEL_RSVD, DAPW_SEL_DEFAULT, DAPW_SEL_DEFAULT,
		DAPW_SEL_DEFAULT}; // see [R10] see [R12]

endmodule // dapw_conn_rom

// *** core/dapw_query_reply.sv ***
// answers pin and device widget queries from the codec controller
`timescale 1ns/1ps
module dapw_query_reply
	import dapw_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic arst_n, // async reset, active low
	dapw_conn_if.cons conn, // fixed connection words
	input wire logic q_valid, // query strobe
	input wire dapw_query_t q_kind, // pin or device query
	input wire logic [1:0] q_xcdr, // transcoder 0..2
	input wire logic mst_active, // multi-stream mode active
	output logic r_valid, // reply strobe
	output logic r_hit, // reply carries data
	output logic [31:0] r_list, // entry and length word
	output logic [31:0] r_sel, // connection select word
	output logic [7:0] r_widget // pipe widget of the transcoder
);

	// pipe widget number for a transcoder
	function automatic logic [7:0] pipe_widget(input logic [1:0] x);
		unique case (x)
			2'h0: pipe_widget = DAPW_WIDGET_PIPE_A; // see [R11]
			2'h1: pipe_widget = DAPW_WIDGET_PIPE_B; // see [R11]
			default: pipe_widget = DAPW_WIDGET_PIPE_C; // see [R11]
		endcase
	endfunction

	logic valid_d, valid_q, hit_d, hit_q;
	logic [31:0] list_d, list_q, sel_d, sel_q;
	logic [7:0] widget_d, widget_q;
	logic take;

	// ***********************************************
	// reply one cycle after the query
	// ***********************************************
	always_comb begin
		// device queries are served only in multi-stream mode
		take = q_valid && (q_xcdr < 2'h3) && (q_kind == DAPW_Q_PIN || mst_active); // see [R6]
		valid_d = q_valid;
		hit_d = take;
		list_d = 32'h0000_0000;
		sel_d = 32'h0000_0000;
		widget_d = 8'h00;
		if (take) begin
			list_d = conn.entry_len[q_xcdr]; // see [R6]
			sel_d = conn.sel_word; // see [R6]
			widget_d = pipe_widget(q_xcdr);
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			valid_q <= 1'b0;
			hit_q <= 1'b0;
			list_q <= 32'h0000_0000;
			sel_q <= 32'h0000_0000;
			widget_q <= 8'h00;
		end else begin
			valid_q <= valid_d;
			hit_q <= hit_d;
			list_q <= list_d;
			sel_q <= sel_d;
			widget_q <= widget_d;
		end
	end

	assign r_valid = valid_q;
	assign r_hit = hit_q;
	assign r_list = list_q;
	assign r_sel = sel_q;
	assign r_widget = widget_q;

endmodule // dapw_query_reply

// *** core/dapw_regs.sv ***
// display audio pin widget register bank, transcoder a status and connection words
// Function
// [R1] audio samples join transcoder a video only with route on, not idle, data present
// [R2] route-on state of transcoder a is reported to audio side as output presence
// [R3] read-write protect-ready bit at bit 1; 0 pending or not ready, 1 ready
// [R4] read-write descriptor-valid bit at bit 0, resets invalid, set only by video software
// [R5] one read-only entry and length word per transcoder a, b, c at own addresses
// [R6] connection words answer pin queries, and device queries in multi-stream mode
// [R7] entry field bits 15:8 names converter widget node 0x03
// [R8] long form bit 7 is hardwired zero for short form items
// [R9] list length in bits 6:0 reads 0000001b
// [R10] select fields pipe c 23:16, b 15:8, a 7:0, each 0fh
// [R11] pipe widgets a 0x00, b 0x01, c 0x02; current index defaults 0x00
// [R12] unused upper bits of connection words are read-only zero
// [R13] software writes protect-ready back to 1 after servicing, about 1 ms later
// [R14] software sets descriptor-valid after descriptor data, clears on init or hotplug
// [R15] idle bit 1 means attached but not streaming, 0 means streaming
// [R16] writes to read-only connection words are ignored
`timescale 1ns/1ps
module dapw_regs
	import dapw_pkg::*;
(
	input wire logic clk_sys, // system clock, 250 MHz
	input wire logic arst_n, // async reset, active low
	input wire logic mmio_wr, // register write strobe
	input wire logic mmio_rd, // register read strobe
	input wire logic [19:0] mmio_addr, // register byte address
	input wire logic [31:0] mmio_wdata, // write data
	output logic [31:0] mmio_rdata, // read data, valid with mmio_rvalid
	output logic mmio_rvalid, // read answer strobe
	input wire logic aud_in_valid, // audio sample available
	input wire logic [31:0] aud_in_data, // audio sample
	output logic vid_aud_valid, // sample merged into transcoder a stream
	output logic [31:0] vid_aud_data, // merged sample
	input wire logic prot_req_a, // protection request from audio unit
	output logic present_a, // digital output present for audio driver
	output logic desc_valid_a, // descriptor valid status to audio side
	output logic prot_ready_a, // protection ready status to audio side
	output logic sink_idle_out_a, // sink attached but not streaming
	input wire logic q_valid, // widget query strobe
	input wire dapw_query_t q_kind, // pin or device query
	input wire logic [1:0] q_xcdr, // queried transcoder
	input wire logic mst_active, // multi-stream mode active
	output logic r_valid, // query reply strobe
	output logic r_hit, // reply carries data
	output logic [31:0] r_list, // entry and length word
	output logic [31:0] r_sel, // connection select word
	output logic [7:0] r_widget // pipe widget number
);

	// ***********************************************
	// fixed connection words and query answers
	// ***********************************************
	dapw_conn_if conn ();

	dapw_conn_rom u_rom (
		.conn(conn.prov)
	);

	dapw_query_reply u_reply (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.conn(conn.cons),
		.q_valid(q_valid),
		.q_kind(q_kind),
		.q_xcdr(q_xcdr),
		.mst_active(mst_active),
		.r_valid(r_valid),
		.r_hit(r_hit),
		.r_list(r_list),
		.r_sel(r_sel),
		.r_widget(r_widget)
	);

	// ***********************************************
	// address decode
	// ***********************************************
	function automatic logic hit(input logic [19:0] a, input logic [19:0] ofs);
		hit = (a == ofs);
	endfunction

	logic wr_status;
	assign wr_status = mmio_wr && hit(mmio_addr, DAPW_OFS_STATUS);

	// ***********************************************
	// status register, transcoder a bits
	// ***********************************************
	logic desc_valid_d, desc_valid_q;
	logic prot_ready_d, prot_ready_q;
	logic route_on_d, route_on_q;
	logic idle_d, idle_q;

	always_comb begin
		desc_valid_d = desc_valid_q;
		prot_ready_d = prot_ready_q;
		route_on_d = route_on_q;
		idle_d = idle_q;
		if (wr_status) begin
			// only software writes reach the descriptor-valid bit
			desc_valid_d = mmio_wdata[DAPW_BIT_DESC_VALID_A]; // see [R4] see [R14]
			prot_ready_d = mmio_wdata[DAPW_BIT_PROT_READY_A]; // see [R3] see [R13]
			route_on_d = mmio_wdata[DAPW_BIT_ROUTE_ON_A];
			idle_d = mmio_wdata[DAPW_BIT_IDLE_A]; // see [R15]
		end
		// a new request wins over a same-cycle software write of ready
		if (prot_req_a) begin
			prot_ready_d = 1'b0; // see [R3]
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			desc_valid_q <= DAPW_RST_DESC_VALID;
			prot_ready_q <= DAPW_RST_PROT_READY;
			route_on_q <= DAPW_RST_ROUTE_ON;
			idle_q <= DAPW_RST_IDLE;
		end else begin
			desc_valid_q <= desc_valid_d;
			prot_ready_q <= prot_ready_d;
			route_on_q <= route_on_d;
			idle_q <= idle_d;
		end
	end

	// ***********************************************
	// status toward the audio side
	// ***********************************************
	assign present_a = route_on_q; // see [R2]
	assign desc_valid_a = desc_valid_q; // see [R14]
	assign prot_ready_a = prot_ready_q;
	assign sink_idle_out_a = idle_q; // see [R15]

	// ***********************************************
	// audio merge into transcoder a stream
	// ***********************************************
	logic merge_ok;
	logic aud_valid_d, aud_valid_q;
	logic [31:0] aud_data_d, aud_data_q;

	// idle sink takes no samples even with routing on
	assign merge_ok = route_on_q && !idle_q && aud_in_valid; // see [R1] see [R15]

	always_comb begin
		aud_valid_d = merge_ok; // see [R1]
		aud_data_d = aud_data_q;
		if (merge_ok) begin
			aud_data_d = aud_in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			aud_valid_q <= 1'b0;
			aud_data_q <= 32'h0000_0000;
		end else begin
			aud_valid_q <= aud_valid_d;
			aud_data_q <= aud_data_d;
		end
	end

	assign vid_aud_valid = aud_valid_q;
	assign vid_aud_data = aud_data_q;

	// ***********************************************
	// read path, answer one cycle after the strobe
	// ***********************************************
	logic [31:0] rd_mux;
	logic [31:0] rdata_d, rdata_q;
	logic rvalid_d, rvalid_q;

	always_comb begin
		rd_mux = 32'h0000_0000;
		// connection words have no write path, so writes leave them as they are
		if (hit(mmio_addr, DAPW_OFS_ENTRY_A)) begin
			rd_mux = conn.entry_len[0]; // see [R5] see [R16]
		end else if (hit(mmio_addr, DAPW_OFS_ENTRY_B)) begin
			rd_mux = conn.entry_len[1]; // see [R5] see [R16]
		end else if (hit(mmio_addr, DAPW_OFS_ENTRY_C)) begin
			rd_mux = conn.entry_len[2]; // see [R5] see [R16]
		end else if (hit(mmio_addr, DAPW_OFS_SELECT)) begin
			rd_mux = conn.sel_word; // see [R10] see [R16]
		end else if (hit(mmio_addr, DAPW_OFS_STATUS)) begin
			rd_mux[DAPW_BIT_DESC_VALID_A] = desc_valid_q;
			rd_mux[DAPW_BIT_PROT_READY_A] = prot_ready_q;
			rd_mux[DAPW_BIT_ROUTE_ON_A] = route_on_q;
			rd_mux[DAPW_BIT_IDLE_A] = idle_q;
		end
		rvalid_d = mmio_rd;
		rdata_d = rdata_q;
		if (mmio_rd) begin
			rdata_d = rd_mux;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 32'h0000_0000;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign mmio_rdata = rdata_q;
	assign mmio_rvalid = rvalid_q;

endmodule // dapw_regs

// *** verification/dapw_regs_asserts.sv ***
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module dapw_regs_chk
	import dapw_pkg::*;
(
	input wire logic clk_sys, // clock
	input wire logic arst_n, // reset
	input wire logic mmio_wr, // write strobe
	input wire logic mmio_rd, // read strobe
	input wire logic [19:0] mmio_addr, // address
	input wire logic [31:0] mmio_wdata, // write data
	input wire logic [31:0] mmio_rdata, // read data
	input wire logic mmio_rvalid, // read answer
	input wire logic aud_in_valid, // sample in
	input wire logic [31:0] aud_in_data, // sample
	input wire logic vid_aud_valid, // merged strobe
	input wire logic [31:0] vid_aud_data, // merged sample
	input wire logic prot_req_a, // protection request
	input wire logic present_a, // route on
	input wire logic desc_valid_a, // descriptor valid
	input wire logic prot_ready_a, // protect ready
	input wire logic sink_idle_out_a, // sink idle
	input wire logic q_valid, // query strobe
	input wire dapw_query_t q_kind, // query kind
	input wire logic [1:0] q_xcdr, // transcoder
	input wire logic mst_active, // multi-stream
	input wire logic r_valid, // reply strobe
	input wire logic r_hit, // reply served
	input wire logic [31:0] r_list, // entry word
	input wire logic [31:0] r_sel, // select word
	input wire logic [7:0] r_widget // widget id
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	sequence s_rd(a); mmio_rd && mmio_addr == a; endsequence
	sequence s_ent;
		s_rd(DAPW_OFS_ENTRY_A) or s_rd(DAPW_OFS_ENTRY_B) or s_rd(DAPW_OFS_ENTRY_C);
	endsequence
	sequence s_wst; mmio_wr && mmio_addr == DAPW_OFS_STATUS && !prot_req_a; endsequence
	sequence s_mrg; aud_in_valid && present_a && !sink_idle_out_a; endsequence
	property p_rvalid; mmio_rd |=> mmio_rvalid; endproperty
	property p_entry; s_ent |=> mmio_rdata == 32'h00000301; endproperty
	property p_sel; s_rd(DAPW_OFS_SELECT) |=> mmio_rdata == 32'h000f0f0f; endproperty
	property p_ready; prot_req_a |=> !prot_ready_a; endproperty
	property p_merge; s_mrg |=> vid_aud_valid && vid_aud_data == $past(aud_in_data); endproperty
	property p_drop; !(aud_in_valid && present_a && !sink_idle_out_a) |=> !vid_aud_valid;
	endproperty
	property p_wst;
		s_wst |=> 32'({sink_idle_out_a, present_a, prot_ready_a, desc_valid_a})
			== ($past(mmio_wdata) & 32'hf);
	endproperty
	property p_qhit;
		q_valid && q_xcdr != 2'h3 && (q_kind == DAPW_Q_PIN || mst_active) |=> r_valid && r_hit
			&& r_list == 32'h00000301 && r_sel == 32'h000f0f0f && r_widget == $past(q_xcdr);
	endproperty
	property p_qmiss;
		q_valid && (q_xcdr == 2'h3 || (q_kind == DAPW_Q_DEVICE && !mst_active))
			|=> r_valid && !r_hit;
	endproperty
	// descriptor-valid moves only on a software write of the status word
	property p_dvhold;
		!(mmio_wr && mmio_addr == DAPW_OFS_STATUS) |=> $stable(desc_valid_a);
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	a_entry: assert property (p_entry) else $error("entry word wrong");
	a_sel: assert property (p_sel) else $error("select word wrong");
	a_ready: assert property (p_ready) else $error("ready not cleared");
	a_merge: assert property (p_merge) else $error("sample not merged");
	a_drop: assert property (p_drop) else $error("sample merged wrongly");
	a_wst: assert property (p_wst) else $error("status outputs wrong");
	a_qhit: assert property (p_qhit) else $error("query reply wrong");
	a_qmiss: assert property (p_qmiss) else $error("refused query served");
	a_dvhold: assert property (p_dvhold) else $error("descriptor valid moved");
endmodule // dapw_regs_chk
bind dapw_regs dapw_regs_chk u_chk (.clk_sys, .arst_n, .mmio_wr, .mmio_rd, .mmio_addr,
	.mmio_wdata, .mmio_rdata, .mmio_rvalid, .aud_in_valid, .aud_in_data, .vid_aud_valid,
	.vid_aud_data, .prot_req_a, .present_a, .desc_valid_a, .prot_ready_a, .sink_idle_out_a,
	.q_valid, .q_kind, .q_xcdr, .mst_active, .r_valid, .r_hit, .r_list, .r_sel, .r_widget);

// *** verification/dapw_codec_model.sv ***
// codec controller model issuing widget queries
`timescale 1ns/1ps
module dapw_codec_model
	import dapw_pkg::*;
(
	input wire logic clk_sys, // clock
	output logic q_valid, // query strobe
	output dapw_query_t q_kind, // query kind
	output logic [1:0] q_xcdr, // transcoder
	output logic mst_active // multi-stream mode
);
	initial begin
		q_valid = 1'b0;
		q_kind = DAPW_Q_PIN;
		q_xcdr = 2'h0;
		mst_active = 1'b0;
	end
	// strobe stays up so queries may follow back to back
	task automatic ask(input dapw_query_t k, input logic [1:0] x, input logic m);
		q_valid = 1'b1;
		q_kind = k;
		q_xcdr = x;
		mst_active = m;
		@(posedge clk_sys);
		#1;
	endtask
	// released lines show inverted values, not the last query
	task automatic quit();
		q_valid = 1'b0;
		q_xcdr = ~q_xcdr;
		q_kind = dapw_query_t'(~q_kind);
	endtask
endmodule // dapw_codec_model

// *** verification/tb_dapw_regs.sv ***
// self-checking bench for the display audio pin widget register bank
`timescale 1ns/1ps
module tb_dapw_regs;
	import dapw_pkg::*;
	logic clk_sys, arst_n, mmio_wr, mmio_rd, aud_in_valid, prot_req_a, mmio_rvalid;
	logic vid_aud_valid, present_a, desc_valid_a, prot_ready_a, sink_idle_out_a;
	logic q_valid, mst_active, r_valid, r_hit;
	logic [19:0] mmio_addr;
	logic [31:0] mmio_wdata, mmio_rdata, aud_in_data, vid_aud_data, r_list, r_sel, seed;
	logic [7:0] r_widget;
	logic [1:0] q_xcdr;
	dapw_query_t q_kind;
	logic [19:0] adr [6];
	logic [31:0] aq [$];
	int n_mismatch, compares, st;
	dapw_regs dut (.clk_sys, .arst_n, .mmio_wr, .mmio_rd, .mmio_addr, .mmio_wdata, .mmio_rdata,
		.mmio_rvalid, .aud_in_valid, .aud_in_data, .vid_aud_valid, .vid_aud_data, .prot_req_a,
		.present_a, .desc_valid_a, .prot_ready_a, .sink_idle_out_a, .q_valid, .q_kind, .q_xcdr,
		.mst_active, .r_valid, .r_hit, .r_list, .r_sel, .r_widget);
	dapw_codec_model u_codec (.clk_sys, .q_valid, .q_kind, .q_xcdr, .mst_active);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] exp_rd(input logic [19:0] a);
		case (a)
			DAPW_OFS_ENTRY_A, DAPW_OFS_ENTRY_B, DAPW_OFS_ENTRY_C: return 32'h00000301;
			DAPW_OFS_SELECT: return 32'h000f0f0f;
			DAPW_OFS_STATUS: return 32'(st);
			default: return 32'h0;
		endcase
	endfunction
	task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_b(input string nm, input logic e, input logic g);
		chk_w(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		mmio_wr = 1'b1;
		mmio_rd = 1'b0;
		mmio_addr = a;
		mmio_wdata = d;
		@(posedge clk_sys);
		#1;
		if (a == DAPW_OFS_STATUS) st = d & 32'hf;
	endtask
	task automatic rd(input logic [19:0] a);
		mmio_rd = 1'b1;
		mmio_wr = 1'b0;
		mmio_addr = a;
		@(posedge clk_sys);
		#1;
		chk_b("rvalid", 1'b1, mmio_rvalid);
		chk_w("rdata", exp_rd(a), mmio_rdata);
		if (a == DAPW_OFS_STATUS) begin
			chk_b("desc_valid", st[0], desc_valid_a);
			chk_b("prot_ready", st[1], prot_ready_a);
			chk_b("present", st[2], present_a);
			chk_b("idle", st[3], sink_idle_out_a);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		#40000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		logic [31:0] v;
		logic e, h;
		{arst_n, mmio_wr, mmio_rd, aud_in_valid, prot_req_a} = 5'h00;
		{mmio_addr, mmio_wdata, aud_in_data} = 84'h0;
		{n_mismatch, compares, st} = 96'h0;
		seed = 32'd31975;
		adr = '{DAPW_OFS_ENTRY_A, DAPW_OFS_ENTRY_B, DAPW_OFS_ENTRY_C, DAPW_OFS_SELECT,
			DAPW_OFS_STATUS, 20'h650b0};
		repeat (20) @(posedge clk_sys);
		#1;
		arst_n = 1'b1;
		foreach (adr[i]) rd(adr[i]);
		repeat (3) begin
			foreach (adr[i]) wr(adr[i], rnd());
			foreach (adr[i]) rd(adr[i]);
		end
		wr(DAPW_OFS_STATUS, 32'h2);
		prot_req_a = 1'b1;
		wr(DAPW_OFS_STATUS, 32'h3);
		prot_req_a = 1'b0;
		st = 1;
		rd(DAPW_OFS_STATUS);
		wr(DAPW_OFS_STATUS, 32'h2);
		rd(DAPW_OFS_STATUS);
		for (int i = 0; i < 128; i++) begin
			v = rnd();
			mmio_wr = (i % 8 == 0);
			mmio_rd = 1'b0;
			mmio_addr = DAPW_OFS_STATUS;
			mmio_wdata = v >> 12;
			aud_in_valid = v[8];
			aud_in_data = v;
			@(posedge clk_sys);
			e = v[8] && st[2] && !st[3];
			if (e) aq.push_back(v);
			if (mmio_wr) st = mmio_wdata & 32'hf;
			#1;
			chk_b("merge_valid", e, vid_aud_valid);
			if (e) chk_w("merge_data", aq.pop_front(), vid_aud_data);
		end
		{mmio_wr, aud_in_valid} = 2'b00;
		for (int m = 0; m < 2; m++) for (int k = 0; k < 2; k++) for (int x = 0; x < 4; x++) begin
			u_codec.ask(dapw_query_t'(k), 2'(x), m[0]);
			h = x != 3 && (k == 0 || m == 1);
			chk_b("r_valid", 1'b1, r_valid);
			chk_b("r_hit", h, r_hit);
			chk_w("r_list", h ? 32'h00000301 : 32'h0, r_list);
			chk_w("r_sel", h ? 32'h000f0f0f : 32'h0, r_sel);
			chk_w("r_widget", h ? 32'(x) : 32'h0, {24'h0, r_widget});
		end
		u_codec.quit();
		// reset in mid-run must bring every status bit back to its reset value
		arst_n = 1'b0;
		st = 0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk_b("reset_merge", 1'b0, vid_aud_valid);
		chk_b("reset_reply", 1'b0, r_valid);
		arst_n = 1'b1;
		rd(DAPW_OFS_STATUS);
		rd(DAPW_OFS_ENTRY_B);
		complete_run();
	end
endmodule // tb_dapw_regs
